// *** edge_timestamp_input_image_test.sv ***
// self-checking bench for the edge and time-stamp input image
`timescale 1ns/1ps
`default_nettype none
`include "etii_defs.vh"
// ==========
module edge_timestamp_input_image_test;
  logic mclk, cyc, stb, we, ack, irq;
  logic ce = 1'b1, rst_n = 1'b0;
  logic [15:0] chanIn = 16'h0, seen = 16'h0, lost = 16'h0, chanOut, keep;
  logic [15:0] stamp [16] = '{default: 16'h0};
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q, edgeSel = 32'hffffffff;
  int error_cnt, compares, cnt, tmo, tk;
  etii_cpu_master cpu (.mclk(mclk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .dat(wdat), .rdat(rdat), .ack(ack));
  etii_input_image uut (.mclk(mclk), .ce(ce), .rst_n(rst_n), .chanIn(chanIn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .chanOut(chanOut), .irq(irq));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge mclk) begin
    cnt <= rst_n ? cnt + 1 : 0;
    tmo <= tmo + 1;
    if (tmo == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  function automatic logic [31:0] model(input logic [5:0] i);
    case (i)
      6'h00: return {24'h0, chanIn[7:0]};
      6'h01: return {24'h0, chanIn[15:8]};
      6'h04: return {24'h0, seen[7:0]};
      6'h05: return {24'h0, seen[15:8]};
      6'h08: return {24'h0, lost[7:0]};
      6'h09: return {24'h0, lost[15:8]};
      default: return (i >= 6'h0c && i <= 6'h28 && i[1:0] == 2'h0) ?
        {stamp[(i - 6'h0c) / 2 + 1], stamp[(i - 6'h0c) / 2]} : 32'h0;
    endcase
  endfunction
  task automatic rd(input logic [5:0] i);
    cpu.xfer(1'b0, i, 32'h0, q);
    chk(q, model(i));
    keep = (i[5:1] == 5'h02) ? (i[0] ? 16'h00ff : 16'hff00) : 16'hffff;
    seen &= keep;
    lost &= keep;
  endtask
  // edges land mid-way between ticks so the expected stamp has no rounding doubt
  task automatic drive(input logic [15:0] v);
    logic [1:0] m;
    @(posedge mclk);
    while (cnt % 50 != 24) @(posedge mclk);
    chanIn <= v;
    for (int n = 0; n < 16; n++) begin
      m = edgeSel[2 * n +: 2];
      if ((v[n] && !chanIn[n] && m[0]) || (!v[n] && chanIn[n] && m[1])) begin
        lost[n] |= seen[n];
        seen[n] = 1'b1;
        stamp[n] = 16'((cnt + 1) / 50);
      end
    end
  endtask
  initial begin
    q = $urandom(32'h54e6c005);
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    rd(`ETII_IDX_EDGE_SEL);
    cpu.xfer(1'b1, `ETII_IDX_EDGE_SEL, edgeSel, q);
    drive(16'h0001);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    cpu.xfer(1'b1, `ETII_IDX_IRQ_MASK, 32'h1, q);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    cpu.xfer(1'b1, `ETII_IDX_IRQ_STAT, 32'h1, q);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    cpu.xfer(1'b1, `ETII_IDX_OUT_CTRL, 32'h5a3c, q);
    chk({16'h0, chanOut}, 32'h5a3c);
    for (int i = 0; i < 14; i++) rd(6'(i));
    // ticker read at a known prescaler phase: one tick per 50 cycles since release
    @(posedge mclk);
    while (cnt % 50 != 24) @(posedge mclk);
    tk = cnt;
    cpu.xfer(1'b0, `ETII_IDX_TICKER, 32'h0, q);
    chk(q, 32'((tk + 2) / 50));
    edgeSel = $urandom;
    cpu.xfer(1'b1, `ETII_IDX_EDGE_SEL, edgeSel, q);
    repeat (80) begin
      if ($urandom % 2) drive(16'($urandom));
      else rd(6'($urandom % 44));
    end
    conclude();
  end
endmodule // edge_timestamp_input_image_test
bind etii_input_image etii_image_asserts chkr (.mclk(mclk), .ce(ce), .rst_n(rst_n),
  .chanIn(chanIn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .chanOut(chanOut));
`default_nettype wire

// *** etii_cpu_master.sv ***
// wishbone master standing in for the controller that reads the image
`timescale 1ns/1ps
`default_nettype none
// ==========
module etii_cpu_master (
  // clock
  input wire mclk,
  // wishbone master side
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat,
  input wire [31:0] rdat,
  input wire ack
);
  initial {cyc, stb, we, adr, sel, dat} = '0;
  task automatic xfer(input logic w, input logic [5:0] i, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge mclk);
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, i, 2'b00, 4'hf, d};
    @(posedge mclk);
    while (ack !== 1'b1) @(posedge mclk);
    r = rdat;
    {cyc, stb} <= 2'b00;
    // released address and data lines show the inverse, so a stale value cannot pass for a live one
    {adr, dat} <= ~{adr, dat};
  endtask
  // stamps are 16 bits wide, so elapsed time is taken modulo the wrap
  function automatic logic [15:0] span(input logic [15:0] a, input logic [15:0] b);
    return b - a;
  endfunction
endmodule // etii_cpu_master
`default_nettype wire

// *** etii_defs.vh ***
// register map, reset values and timing counts of the input image block
`ifndef ETII_DEFS_VH
`define ETII_DEFS_VH

// ==========================================================
// register indices (byte address is four times the index)
`define ETII_IDX_STATE_LO 6'h00
`define ETII_IDX_STATE_HI 6'h01
`define ETII_IDX_RSVD_A 6'h02
`define ETII_IDX_SEEN_LO 6'h04
`define ETII_IDX_SEEN_HI 6'h05
`define ETII_IDX_RSVD_B 6'h06
`define ETII_IDX_LOST_LO 6'h08
`define ETII_IDX_LOST_HI 6'h09
`define ETII_IDX_RSVD_C 6'h0a
`define ETII_IDX_STAMP_FIRST 6'h0c
`define ETII_IDX_STAMP_LAST 6'h28
`define ETII_IDX_STAMP_P0 6'h0c
`define ETII_IDX_STAMP_P1 6'h10
`define ETII_IDX_STAMP_P2 6'h14
`define ETII_IDX_STAMP_P3 6'h18
`define ETII_IDX_STAMP_P4 6'h1c
`define ETII_IDX_STAMP_P5 6'h20
`define ETII_IDX_STAMP_P6 6'h24
`define ETII_IDX_STAMP_P7 6'h28
`define ETII_IDX_EDGE_SEL 6'h30
`define ETII_IDX_IRQ_STAT 6'h31
`define ETII_IDX_IRQ_MASK 6'h32
`define ETII_IDX_OUT_CTRL 6'h33
`define ETII_IDX_TICKER 6'h34

// ==========================================================
// image sizes
`define ETII_IN_BYTES 48
`define ETII_OUT_BYTES 2
`define ETII_CHANNELS 16
`define ETII_STAMP_W 16

// ==========================================================
// edge selector codes
`define ETII_SEL_NONE 2'h0
`define ETII_SEL_RISE 2'h1
`define ETII_SEL_FALL 2'h2
`define ETII_SEL_BOTH 2'h3

// ==========================================================
// reset values
`define ETII_RST_EDGE_SEL 32'h00000000
`define ETII_RST_IRQ_MASK 16'h0000
`define ETII_RST_OUT_CTRL 16'h0000
`define ETII_RST_TICKER 32'h00000000

// ==========================================================
// timing
`define ETII_CLK_NS 20
`define ETII_TICK_NS 1000
`define ETII_TICK_CYCLES (`ETII_TICK_NS / `ETII_CLK_NS)
// last prescaler count of one microsecond, sized for the 6-bit prescaler
`define ETII_TICK_LAST 6'h31

`endif

// *** etii_image_asserts.sv ***
// bus and edge-flag checker for the input image block
`timescale 1ns/1ps
`default_nettype none
// ==========
module etii_image_asserts (
  // clock and reset
  input wire mclk,
  input wire ce,
  input wire rst_n,
  // watched ports
  input wire [15:0] chanIn,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [15:0] chanOut
);
  // input changes since each edge byte was last read; a superset of the real flags
  logic [15:0] moved;
  logic [15:0] prevIn;
  wire take = ce && wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire [5:0] idx = wb_adr_i[7:2];
  wire [15:0] allow = moved | (chanIn ^ prevIn);
  wire [15:0] keep = (take && !wb_we_i && idx[5:1] == 5'h02) ?
    (idx[0] ? 16'h00ff : 16'hff00) : 16'hffff;
  always_ff @(posedge mclk)
    if (!rst_n) {moved, prevIn} <= 32'h0;
    else if (ce) {moved, prevIn} <= {(moved & keep) | (chanIn ^ prevIn), chanIn};
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_rd; take && !wb_we_i; endsequence
  sequence s_wr; take && wb_we_i; endsequence
  property p_ackNext; take |=> wb_ack_o; endproperty
  property p_ackOne; wb_ack_o && ce |=> !wb_ack_o; endproperty
  property p_ackCause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
  property p_state; s_rd ##0 (idx[5:1] == 5'h00) |=>
    wb_dat_o == {24'h0, $past(idx[0] ? chanIn[15:8] : chanIn[7:0])}; endproperty
  property p_rsvd; s_rd ##0 (idx inside {6'h02, 6'h03, 6'h06, 6'h0d}) |=> wb_dat_o == 32'h0;
  endproperty
  property p_hold; !(wb_ack_o && !wb_we_i) |-> $stable(wb_dat_o); endproperty
  property p_outWr; s_wr ##0 (idx == 6'h33 && wb_sel_i[1:0] == 2'h3) |=>
    chanOut == $past(wb_dat_i[15:0]); endproperty
  property p_seen; s_rd ##0 (idx[5:1] == 5'h02) |=>
    wb_dat_o == {24'h0, wb_dat_o[7:0] & $past(idx[0] ? allow[15:8] : allow[7:0])}; endproperty
  a_ackNext: assert property (p_ackNext) else $error("ack missing");
  a_ackOne: assert property (p_ackOne) else $error("ack too long");
  a_ackCause: assert property (p_ackCause) else $error("ack unasked");
  a_state: assert property (p_state) else $error("state byte wrong");
  a_rsvd: assert property (p_rsvd) else $error("reserved not zero");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_outWr: assert property (p_outWr) else $error("output image wrong");
  a_seen: assert property (p_seen) else $error("flag without edge");
endmodule // etii_image_asserts
`default_nettype wire

// *** etii_input_image.v ***
// edge and time-stamp input image with wishbone register access
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "etii_defs.vh"

// Summary of operation
// - image spans 48 input, 2 output bytes
// - bytes 0/1 show live channel states
// - bytes 4/5 flag edges since last read
// - reading edge flags clears them
// - bytes 8/9 flag more than one edge
// - edge stores current ticker in channel slot
// - stamps keep ticker's low 16 bits
// - stamp words 12..40, even channel low half
// - microsecond ticker runs from reset release
// - two-bit selector picks stamping edges
module etii_input_image (
  // clock, enable, reset
  input wire mclk,
  input wire ce,
  input wire rst_n,
  // filtered channel inputs
  input wire [15:0] chanIn,
  // classic wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // output image and interrupt
  output reg [15:0] chanOut,
  output reg irq
);

  // ==========================================================
  // helpers

  function edgeHit;
    input [1:0] mode;
    input prev;
    input cur;
    begin
      case (mode)
        `ETII_SEL_RISE: edgeHit = ~prev & cur;
        `ETII_SEL_FALL: edgeHit = prev & ~cur;
        `ETII_SEL_BOTH: edgeHit = prev ^ cur;
        default: edgeHit = 1'b0;
      endcase
    end
  endfunction

  function [31:0] laneMerge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0] sel;
    integer b;
    begin
      laneMerge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          laneMerge[8*b +: 8] = dat[8*b +: 8];
        end
      end
    end
  endfunction

  // ==========================================================
  // microsecond ticker

  localparam [5:0] TICK_LAST = `ETII_TICK_LAST;

  reg [5:0] preDiv;
  reg [31:0] ticker;

  // one strobe per microsecond from the prescaler
  wire tickStep = (preDiv == TICK_LAST);

  always @(posedge mclk) begin
    if (!rst_n) begin
      preDiv <= 6'h00;
    end else if (ce) begin
      if (tickStep) begin
        preDiv <= 6'h00;
      end else begin
        preDiv <= preDiv + 6'h01;
      end
    end
  end

  // starts at reset release and simply wraps; readers handle the wrap
  always @(posedge mclk) begin
    if (!rst_n) begin
      ticker <= `ETII_RST_TICKER;
    end else if (ce && tickStep) begin
      ticker <= ticker + 32'h00000001;
    end
  end

  // ==========================================================
  // bus decode

  wire busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire busWr = busReq & wb_we_i;
  wire busRd = busReq & ~wb_we_i;
  wire [5:0] idx = wb_adr_i[7:2];

  // read of an edge-flag byte clears that byte's flags
  wire rdSeenLo = busRd & (idx == `ETII_IDX_SEEN_LO);
  wire rdSeenHi = busRd & (idx == `ETII_IDX_SEEN_HI);
  wire [15:0] seenClr = {{8{rdSeenHi}}, {8{rdSeenLo}}};

  // ==========================================================
  // configuration registers

  reg [31:0] edgeSel;
  reg [15:0] irqMask;
  reg [31:0] selMerged;
  reg [31:0] maskMerged;
  reg [31:0] outMerged;
  reg [15:0] irqW1c;

  always @* begin
    selMerged = laneMerge(edgeSel, wb_dat_i, wb_sel_i);
    maskMerged = laneMerge({16'h0000, irqMask}, wb_dat_i, wb_sel_i);
    outMerged = laneMerge({16'h0000, chanOut}, wb_dat_i, wb_sel_i);
    irqW1c = 16'h0000;
    if (busWr && idx == `ETII_IDX_IRQ_STAT) begin
      if (wb_sel_i[0]) begin
        irqW1c[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        irqW1c[15:8] = wb_dat_i[15:8];
      end
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      edgeSel <= `ETII_RST_EDGE_SEL;
    end else if (ce && busWr && idx == `ETII_IDX_EDGE_SEL) begin
      edgeSel <= selMerged;
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      irqMask <= `ETII_RST_IRQ_MASK;
    end else if (ce && busWr && idx == `ETII_IDX_IRQ_MASK) begin
      irqMask <= maskMerged[15:0];
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      chanOut <= `ETII_RST_OUT_CTRL;
    end else if (ce && busWr && idx == `ETII_IDX_OUT_CTRL) begin
      chanOut <= outMerged[15:0];
    end
  end

  // ==========================================================
  // per-channel edge detection

  reg [15:0] prevIn;
  wire [15:0] hit;

  // every edge is judged against the sample of the previous enabled cycle
  always @(posedge mclk) begin
    if (!rst_n) begin
      prevIn <= 16'h0000;
    end else if (ce) begin
      prevIn <= chanIn;
    end
  end

  // ==========================================================
  // flags and stamp slots

  wire [15:0] edgeSeen;
  wire [15:0] edgeLost;
  wire [15:0] irqStat;
  wire [16*`ETII_CHANNELS-1:0] stampFlat;

  genvar c;
  generate
    for (c = 0; c < `ETII_CHANNELS; c = c + 1) begin : gChan
      reg seenBit;
      reg lostBit;
      reg statBit;
      reg [`ETII_STAMP_W-1:0] slot;

      assign hit[c] = edgeHit(edgeSel[2*c +: 2], prevIn[c], chanIn[c]);

      // a new edge wins over the clearing read
      always @(posedge mclk) begin
        if (!rst_n) begin
          seenBit <= 1'b0;
        end else if (ce) begin
          if (hit[c]) begin
            seenBit <= 1'b1;
          end else if (seenClr[c]) begin
            seenBit <= 1'b0;
          end
        end
      end

      // lost only if an unread edge was already pending
      always @(posedge mclk) begin
        if (!rst_n) begin
          lostBit <= 1'b0;
        end else if (ce) begin
          if (hit[c] && seenBit && !seenClr[c]) begin
            lostBit <= 1'b1;
          end else if (seenClr[c]) begin
            lostBit <= 1'b0;
          end
        end
      end

      // the slot keeps the latest edge; the lost flag says one was overwritten
      always @(posedge mclk) begin
        if (!rst_n) begin
          slot <= 16'h0000;
        end else if (ce && hit[c]) begin
          slot <= ticker[`ETII_STAMP_W-1:0];
        end
      end

      // sticky status, write one to clear; a new edge wins
      always @(posedge mclk) begin
        if (!rst_n) begin
          statBit <= 1'b0;
        end else if (ce) begin
          if (hit[c]) begin
            statBit <= 1'b1;
          end else if (irqW1c[c]) begin
            statBit <= 1'b0;
          end
        end
      end

      assign edgeSeen[c] = seenBit;
      assign edgeLost[c] = lostBit;
      assign irqStat[c] = statBit;
      assign stampFlat[16*c +: 16] = slot;
    end
  endgenerate

  // ==========================================================
  // read data

  // byte registers sit in the low lane; upper lanes read as zero
  function [31:0] byteWord;
    input [7:0] b;
    begin
      byteWord = {24'h000000, b};
    end
  endfunction

  // stamp word of a channel pair: even channel in the low half
  function [31:0] stampWord;
    input [255:0] flat;
    input [2:0] pr;
    begin
      stampWord = flat[32*pr +: 32];
    end
  endfunction

  reg [31:0] rdData;

  always @* begin
    rdData = 32'h00000000;
    case (idx)
      `ETII_IDX_STATE_LO: rdData = byteWord(chanIn[7:0]);
      `ETII_IDX_STATE_HI: rdData = byteWord(chanIn[15:8]);
      `ETII_IDX_SEEN_LO: rdData = byteWord(edgeSeen[7:0]);
      `ETII_IDX_SEEN_HI: rdData = byteWord(edgeSeen[15:8]);
      `ETII_IDX_LOST_LO: rdData = byteWord(edgeLost[7:0]);
      `ETII_IDX_LOST_HI: rdData = byteWord(edgeLost[15:8]);
      `ETII_IDX_EDGE_SEL: rdData = edgeSel;
      `ETII_IDX_IRQ_STAT: rdData = {16'h0000, irqStat};
      `ETII_IDX_IRQ_MASK: rdData = {16'h0000, irqMask};
      `ETII_IDX_OUT_CTRL: rdData = {16'h0000, chanOut};
      `ETII_IDX_TICKER: rdData = ticker;
      `ETII_IDX_STAMP_P0: rdData = stampWord(stampFlat, 3'h0);
      `ETII_IDX_STAMP_P1: rdData = stampWord(stampFlat, 3'h1);
      `ETII_IDX_STAMP_P2: rdData = stampWord(stampFlat, 3'h2);
      `ETII_IDX_STAMP_P3: rdData = stampWord(stampFlat, 3'h3);
      `ETII_IDX_STAMP_P4: rdData = stampWord(stampFlat, 3'h4);
      `ETII_IDX_STAMP_P5: rdData = stampWord(stampFlat, 3'h5);
      `ETII_IDX_STAMP_P6: rdData = stampWord(stampFlat, 3'h6);
      `ETII_IDX_STAMP_P7: rdData = stampWord(stampFlat, 3'h7);
      // reserved and unmapped words read as zero
      default: rdData = 32'h00000000;
    endcase
  end

  // ==========================================================
  // bus answer

  // one-cycle answer; ack drops the cycle after it rose
  always @(posedge mclk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else if (ce) begin
      wb_ack_o <= busReq;
    end
  end

  // read data holds until the next read, so a slow master still sees it
  always @(posedge mclk) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h00000000;
    end else if (ce && busRd) begin
      wb_dat_o <= rdData;
    end
  end

  // ==========================================================
  // interrupt

  wire next_irq = |(irqStat & irqMask);

  // registered so the pin cannot glitch while status and mask change together
  always @(posedge mclk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= next_irq;
    end
  end

endmodule // etii_input_image

`default_nettype wire
